// *** verilog/cler_map.vh ***
/*
 Constants for the control link error reporter: register offsets, status
 bit positions, report kinds, character codes and message lengths.
 Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef CLER_MAP_VH
`define CLER_MAP_VH

// Register offsets (word index on the plain register port)
`define CLER_OFS_STATUS    4'h0
`define CLER_OFS_MASK      4'h1
`define CLER_OFS_ALARM     4'h2
`define CLER_OFS_UTC_HI    4'h3
`define CLER_OFS_UTC_LO    4'h4
`define CLER_OFS_INFO      4'h5

// Status and mask bit positions
`define CLER_ST_GARBAGE    0
`define CLER_ST_UNKNOWN    1
`define CLER_ST_SYNTAX     2
`define CLER_ST_SEMANTIC   3
`define CLER_ST_SEQUENCE   4
`define CLER_ST_ALARM_REQ  5
`define CLER_ST_STREAM_REQ 6
`define CLER_ST_OVERRUN    7
`define CLER_ST_W          8

// Reset values
`define CLER_RST_MASK      8'h00
`define CLER_RST_ALARM     10'h3FF
`define CLER_RST_UTC       32'h30303030

// Report kinds held while a report is sent
`define CLER_K_GARBAGE     3'h0
`define CLER_K_UNKNOWN     3'h1
`define CLER_K_SYNTAX      3'h2
`define CLER_K_SEMANTIC    3'h3
`define CLER_K_SEQUENCE    3'h4
`define CLER_K_ALM         3'h5

// Command and extension words, one ASCII character per byte
`define CLER_W_ERR_REPORT   56'h50524552524F52
`define CLER_W_ALARM_STATUS 56'h414C41524D5354
`define CLER_W_STREAM_ERR   56'h53544552524F52
`define CLER_X_GARBAGE      24'h474247
`define CLER_X_UNKNOWN      24'h554B4E
`define CLER_X_SYNTAX       24'h53594E
`define CLER_X_SEMANTIC     24'h53454D
`define CLER_X_SEQUENCE     24'h505254
`define CLER_X_REPORT       24'h444546
`define CLER_X_REQUEST      24'h494E46

// Single characters
`define CLER_C_SPACE       8'h20
`define CLER_C_ZERO        8'h30
`define CLER_C_ONE         8'h31
`define CLER_C_NA          8'h58

// Alarm code per alarm: 00 inactive, 01 active, 1x not available
`define CLER_AL_OFF        2'h0
`define CLER_AL_ON         2'h1

// Message lengths in characters, minus one (index of last character)
`define CLER_LAST_GARBAGE  5'h0A
`define CLER_LAST_ECHO     5'h16
`define CLER_LAST_ALM      5'h19

`endif

// *** verilog/cler_reporter.v ***
/*
 Control link error reporter: takes one parsed control message at a time,
 answers protocol errors with a single report, answers alarm status
 requests, and flags stream error requests to the stream reporter.
 Assumes an upstream parser that splits messages into a 7-character
 command word and a 3-character extension word with error class flags,
 and a downstream character sink with a ready handshake.
*/
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cler_map.vh"

module cler_reporter #(
  parameter DW       = 32,                // Register data width
  parameter MSG_MAX  = 26                 // Longest report in characters
) (
  input  wire           mclk,
  input  wire           rst_b,
  input  wire [3:0]     reg_addr,
  input  wire [DW-1:0]  reg_wdata,
  input  wire           reg_wr,
  input  wire           reg_rd,
  output reg  [DW-1:0]  reg_rdata,
  input  wire           rx_valid,
  output wire           rx_ready,
  input  wire [55:0]    rx_cmd,
  input  wire [23:0]    rx_ext,
  input  wire           rx_garbage,
  input  wire           rx_unknown,
  input  wire           rx_syntax_err,
  input  wire           rx_semantic_err,
  input  wire           rx_sequence_err,
  output reg            tx_valid,
  output reg  [7:0]     tx_char,
  output reg            tx_last,
  input  wire           tx_ready,
  output reg            stream_req,
  output reg            irq
);

  // One-hot states
  localparam [2:0] S_IDLE = 3'b001;       // Waiting for a message
  localparam [2:0] S_LOAD = 3'b010;       // Present first character
  localparam [2:0] S_SEND = 3'b100;       // Stream characters out

  localparam MW = MSG_MAX * 8;            // Message vector width

  // Decode of a received word pair, used for both request kinds
  function is_pair;
    input [55:0] cmd;
    input [23:0] ext;
    input [55:0] want_cmd;
    input [23:0] want_ext;
    begin
      is_pair = (cmd == want_cmd) && (ext == want_ext);
    end
  endfunction

  // One alarm code to its state character
  function [7:0] alarm_char;
    input [1:0] code;
    begin
      if (code == `CLER_AL_OFF) begin
        alarm_char = `CLER_C_ZERO;
      end else if (code == `CLER_AL_ON) begin
        alarm_char = `CLER_C_ONE;
      end else begin
        alarm_char = `CLER_C_NA;
      end
    end
  endfunction

  reg  [2:0]              state_reg;      // Sequencer state
  reg  [2:0]              state_next;
  reg  [2:0]              kind_reg;       // Report being sent
  reg  [2:0]              kind_next;
  reg  [55:0]             cmd_reg;        // Echoed command word
  reg  [23:0]             ext_reg;        // Echoed extension word
  reg  [4:0]              idx_reg;        // Index of shown character
  reg  [4:0]              idx_next;
  reg  [`CLER_ST_W-1:0]   status_reg;     // Sticky events
  reg  [`CLER_ST_W-1:0]   status_next;
  reg  [`CLER_ST_W-1:0]   mask_reg;       // Interrupt enables
  reg  [9:0]              alarm_reg;      // Five 2-bit alarm codes
  reg  [31:0]             utc_hi_reg;     // UTC chars HH:M
  reg  [31:0]             utc_lo_reg;     // UTC chars M:SS
  reg  [`CLER_ST_W-1:0]   event_set;      // Events this cycle
  reg                     report_hit;     // Accepted message needs a report
  reg  [MW-1:0]           msg_vec;        // Current report, first char on top
  reg  [4:0]              last_idx;       // Last character index of report
  reg  [39:0]             alarm_chars;    // Five state characters
  integer                 i;

  wire                    accept = rx_valid & state_reg[0];
  wire                    drop   = rx_valid & ~state_reg[0];
  wire                    tx_go  = tx_valid & tx_ready;
  wire [4:0]              sel_idx;        // Character to present next
  wire [MW-1:0]           msg_shift;
  wire [`CLER_ST_W-1:0]   w1c;            // Software clear bits

  // Ready only while idle; a message offered while busy is dropped and flagged in the overrun status bit
  assign rx_ready = state_reg[0];

  // Classify the accepted message; one report only, in fixed priority
  always @* begin
    event_set  = {`CLER_ST_W{1'b0}};
    kind_next  = kind_reg;
    report_hit = 1'b0;
    if (accept) begin
      if (rx_garbage) begin
        kind_next  = `CLER_K_GARBAGE;
        report_hit = 1'b1;
        event_set[`CLER_ST_GARBAGE] = 1'b1;
      end else if (rx_unknown) begin
        kind_next  = `CLER_K_UNKNOWN;
        report_hit = 1'b1;
        event_set[`CLER_ST_UNKNOWN] = 1'b1;
      end else if (rx_syntax_err) begin
        kind_next  = `CLER_K_SYNTAX;
        report_hit = 1'b1;
        event_set[`CLER_ST_SYNTAX] = 1'b1;
      end else if (rx_semantic_err) begin
        kind_next  = `CLER_K_SEMANTIC;
        report_hit = 1'b1;
        event_set[`CLER_ST_SEMANTIC] = 1'b1;
      end else if (rx_sequence_err) begin
        kind_next  = `CLER_K_SEQUENCE;
        report_hit = 1'b1;
        event_set[`CLER_ST_SEQUENCE] = 1'b1;
      end else if (is_pair(rx_cmd, rx_ext, `CLER_W_ALARM_STATUS, `CLER_X_REQUEST)) begin
        kind_next  = `CLER_K_ALM;
        report_hit = 1'b1;
        event_set[`CLER_ST_ALARM_REQ] = 1'b1;
      end else if (is_pair(rx_cmd, rx_ext, `CLER_W_STREAM_ERR, `CLER_X_REQUEST)) begin
        event_set[`CLER_ST_STREAM_REQ] = 1'b1;
      end
    end
    event_set[`CLER_ST_OVERRUN] = drop;
  end

  // Alarm state characters, frame format alarm first
  always @* begin
    alarm_chars = 40'h0000000000;
    for (i = 0; i < 5; i = i + 1) begin
      alarm_chars[i*8 +: 8] = alarm_char(alarm_reg[i*2 +: 2]);
    end
  end

  // Build the whole report as a character vector, zero padded at the end
  always @* begin
    msg_vec  = {MW{1'b0}};
    last_idx = `CLER_LAST_ECHO;
    case (kind_reg)
      `CLER_K_GARBAGE: begin
        // No valid words to echo, so only the two words go out
        msg_vec  = {`CLER_W_ERR_REPORT, `CLER_C_SPACE, `CLER_X_GARBAGE,
                    {(MW-88){1'b0}}};
        last_idx = `CLER_LAST_GARBAGE;
      end
      `CLER_K_UNKNOWN: begin
        msg_vec = {`CLER_W_ERR_REPORT, `CLER_C_SPACE, `CLER_X_UNKNOWN,
                   `CLER_C_SPACE, cmd_reg, `CLER_C_SPACE, ext_reg, {(MW-184){1'b0}}};
      end
      `CLER_K_SYNTAX: begin
        msg_vec = {`CLER_W_ERR_REPORT, `CLER_C_SPACE, `CLER_X_SYNTAX,
                   `CLER_C_SPACE, cmd_reg, `CLER_C_SPACE, ext_reg, {(MW-184){1'b0}}};
      end
      `CLER_K_SEMANTIC: begin
        msg_vec = {`CLER_W_ERR_REPORT, `CLER_C_SPACE, `CLER_X_SEMANTIC,
                   `CLER_C_SPACE, cmd_reg, `CLER_C_SPACE, ext_reg, {(MW-184){1'b0}}};
      end
      `CLER_K_SEQUENCE: begin
        msg_vec = {`CLER_W_ERR_REPORT, `CLER_C_SPACE, `CLER_X_SEQUENCE,
                   `CLER_C_SPACE, cmd_reg, `CLER_C_SPACE, ext_reg, {(MW-184){1'b0}}};
      end
      default: begin
        // Alarm report: state field then start time of that state
        msg_vec  = {`CLER_W_ALARM_STATUS, `CLER_C_SPACE, `CLER_X_REPORT,
                    `CLER_C_SPACE, alarm_chars[7:0], alarm_chars[15:8],
                    alarm_chars[23:16], alarm_chars[31:24], alarm_chars[39:32],
                    `CLER_C_SPACE, utc_hi_reg, utc_lo_reg};
        last_idx = `CLER_LAST_ALM;
      end
    endcase
  end

  // Pick the character to present: first one on load, else the following one
  assign sel_idx   = state_reg[1] ? 5'h00 : (idx_reg + 5'h01);
  assign msg_shift = msg_vec << {sel_idx, 3'b000};

  // Sequencer next state
  always @* begin
    state_next = state_reg;
    idx_next   = idx_reg;
    case (state_reg)
      S_IDLE: begin
        if (report_hit) begin
          state_next = S_LOAD;
        end
      end
      S_LOAD: begin
        state_next = S_SEND;
        idx_next   = 5'h00;
      end
      S_SEND: begin
        // Sink may stall; hold the character until taken
        if (tx_go) begin
          if (tx_last) begin
            state_next = S_IDLE;
          end else begin
            idx_next = idx_reg + 5'h01;
          end
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Sequencer and latched message words
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      kind_reg  <= `CLER_K_GARBAGE;
      idx_reg   <= 5'h00;
      cmd_reg   <= 56'h00000000000000;
      ext_reg   <= 24'h000000;
    end else begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      idx_reg   <= idx_next;
      if (report_hit) begin
        // Words held so the echo stays put while the parser moves on
        cmd_reg <= rx_cmd;
        ext_reg <= rx_ext;
      end
    end
  end

  // Character output, registered
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= 1'b0;
      tx_char  <= 8'h00;
      tx_last  <= 1'b0;
    end else if (state_reg[1]) begin
      tx_valid <= 1'b1;
      tx_char  <= msg_shift[MW-1 -: 8];
      tx_last  <= (last_idx == 5'h00);
    end else if (state_reg[2] && tx_go) begin
      tx_valid <= ~tx_last;
      tx_char  <= tx_last ? 8'h00 : msg_shift[MW-1 -: 8];
      tx_last  <= ~tx_last && (sel_idx == last_idx);
    end
  end

  // Stream error request pulse to the stream reporter
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stream_req <= 1'b0;
    end else begin
      stream_req <= event_set[`CLER_ST_STREAM_REQ];
    end
  end

  // Write-one-to-clear; a new event in the same cycle wins over the clear
  assign w1c = (reg_wr && (reg_addr == `CLER_OFS_STATUS)) ? reg_wdata[`CLER_ST_W-1:0]
                                                           : {`CLER_ST_W{1'b0}};

  always @* begin
    status_next = (status_reg & ~w1c) | event_set;
  end

  // Registers written by software, and status
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= {`CLER_ST_W{1'b0}};
      mask_reg   <= `CLER_RST_MASK;
      alarm_reg  <= `CLER_RST_ALARM;
      utc_hi_reg <= `CLER_RST_UTC;
      utc_lo_reg <= `CLER_RST_UTC;
    end else begin
      status_reg <= status_next;
      if (reg_wr) begin
        if (reg_addr == `CLER_OFS_MASK) begin
          mask_reg <= reg_wdata[`CLER_ST_W-1:0];
        end else if (reg_addr == `CLER_OFS_ALARM) begin
          alarm_reg <= reg_wdata[9:0];
        end else if (reg_addr == `CLER_OFS_UTC_HI) begin
          utc_hi_reg <= reg_wdata[31:0];
        end else if (reg_addr == `CLER_OFS_UTC_LO) begin
          utc_lo_reg <= reg_wdata[31:0];
        end
      end
    end
  end

  // Level interrupt from unmasked sticky bits
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & mask_reg);
    end
  end

  // Read data one cycle after the strobe, zero otherwise and when unmapped
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= {DW{1'b0}};
    end else if (reg_rd) begin
      if (reg_addr == `CLER_OFS_STATUS) begin
        reg_rdata <= {{(DW-`CLER_ST_W){1'b0}}, status_reg};
      end else if (reg_addr == `CLER_OFS_MASK) begin
        reg_rdata <= {{(DW-`CLER_ST_W){1'b0}}, mask_reg};
      end else if (reg_addr == `CLER_OFS_ALARM) begin
        reg_rdata <= {{(DW-10){1'b0}}, alarm_reg};
      end else if (reg_addr == `CLER_OFS_UTC_HI) begin
        reg_rdata <= utc_hi_reg;
      end else if (reg_addr == `CLER_OFS_UTC_LO) begin
        reg_rdata <= utc_lo_reg;
      end else if (reg_addr == `CLER_OFS_INFO) begin
        reg_rdata <= {{(DW-6){1'b0}}, kind_reg, state_reg};
      end else begin
        reg_rdata <= {DW{1'b0}};
      end
    end else begin
      reg_rdata <= {DW{1'b0}};
    end
  end

endmodule // cler_reporter

`default_nettype wire

// *** dv/cler_chk_assertions.sv ***
/*
 Port checker for cler_reporter: report start, character hold, report
 lengths, ready return and read data timing.
 Assumes binding onto cler_reporter; one clock, async active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cler_map.vh"
module cler_chk #(
  parameter DW = 32
) (
  input wire logic          mclk,
  input wire logic          rst_b,
  input wire logic          reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  input wire logic          rx_valid,
  input wire logic          rx_ready,
  input wire logic [55:0]   rx_cmd,
  input wire logic [23:0]   rx_ext,
  input wire logic          rx_garbage,
  input wire logic          rx_unknown,
  input wire logic          rx_syntax_err,
  input wire logic          rx_semantic_err,
  input wire logic          rx_sequence_err,
  input wire logic          tx_valid,
  input wire logic [7:0]    tx_char,
  input wire logic          tx_last,
  input wire logic          tx_ready,
  input wire logic          stream_req
);
  logic [4:0] cnt_reg;  // Characters taken in this report
  logic [1:0] kind_reg; // 1 garbage, 2 echo, 3 alarm
  wire acc  = rx_valid && rx_ready;
  wire errs = rx_garbage | rx_unknown | rx_syntax_err | rx_semantic_err | rx_sequence_err;
  wire alm  = rx_cmd == `CLER_W_ALARM_STATUS && rx_ext == `CLER_X_REQUEST;
  wire stq  = rx_cmd == `CLER_W_STREAM_ERR && rx_ext == `CLER_X_REQUEST;
  wire take = tx_valid && tx_ready;

  // Length tracking, restarted on every accepted message
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg  <= 5'h00;
      kind_reg <= 2'h0;
    end else if (acc) begin
      cnt_reg  <= 5'h00;
      kind_reg <= rx_garbage ? 2'h1 : errs ? 2'h2 : alm ? 2'h3 : 2'h0;
    end else if (take) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read slot");
  a_report_start: assert property (acc && errs |=> !tx_valid ##1 (tx_valid && tx_char == 8'h50))
    else $error("error report did not start");
  a_alarm_answer: assert property (acc && !errs && alm |=> ##1 (tx_valid && tx_char == 8'h41))
    else $error("alarm request not answered");
  a_char_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char) && $stable(tx_last))
    else $error("character changed while stalled");
  a_busy_ready: assert property (tx_valid |-> !rx_ready)
    else $error("ready while report runs");
  a_ready_back: assert property (take && tx_last |=> !tx_valid && rx_ready)
    else $error("no return to idle after report");
  a_gbg_len: assert property (take && tx_last && kind_reg == 2'h1 |-> cnt_reg == 5'd10)
    else $error("garbage report length wrong");
  a_echo_len: assert property (take && tx_last && kind_reg == 2'h2 |-> cnt_reg == 5'd22)
    else $error("echo report length wrong");
  a_alarm_len: assert property (take && tx_last && kind_reg == 2'h3 |-> cnt_reg == 5'd25)
    else $error("alarm report length wrong");
  a_stream_pulse: assert property (acc && !errs && stq |=> stream_req ##1 !stream_req)
    else $error("stream request pulse wrong");
endmodule // cler_chk

bind cler_reporter cler_chk #(.DW(DW)) u_chk (.mclk(mclk), .rst_b(rst_b), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_cmd(rx_cmd), .rx_ext(rx_ext),
  .rx_garbage(rx_garbage), .rx_unknown(rx_unknown), .rx_syntax_err(rx_syntax_err),
  .rx_semantic_err(rx_semantic_err), .rx_sequence_err(rx_sequence_err), .tx_valid(tx_valid),
  .tx_char(tx_char), .tx_last(tx_last), .tx_ready(tx_ready), .stream_req(stream_req));
`default_nettype wire

// *** dv/cler_sink.sv ***
/*
 Character sink standing for the remote entity's receiver.
 Assumes the bench supplies a stall request each cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module cler_sink (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic stall,
  output var logic  tx_ready
);
  // Registered ready; a slow remote holds characters back
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) tx_ready <= 1'b0;
    else tx_ready <= !stall;
  end
endmodule // cler_sink
`default_nettype wire

// *** dv/cler_reporter_test.sv ***
/*
 Self-checking bench for cler_reporter: error reports, alarm and stream
 requests, status, mask and interrupt.
 Assumes cler_map.vh and the sink model; one 40 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cler_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module cler_reporter_test;
  logic        mclk, rst_b, reg_wr, reg_rd, rx_valid, stall, slow, rd_seen;
  logic        rx_ready, tx_valid, tx_last, tx_ready, stream_req, irq;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed;
  logic [55:0] rx_cmd, c;
  logic [23:0] rx_ext, e;
  logic [4:0]  rx_err, f;
  logic [7:0]  tx_char;
  logic [8:0]  t;
  logic [23:0] xw [5] = '{`CLER_X_GARBAGE, `CLER_X_UNKNOWN, `CLER_X_SYNTAX, `CLER_X_SEMANTIC, `CLER_X_SEQUENCE};
  logic [8:0]  tx_q [$]; // Expected {last, char}
  logic [31:0] rd_q [$]; // Expected read data
  int          err_count, n_checks;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] ch();
    return 8'h41 + 8'(rnd() % 26);
  endfunction

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  cler_reporter dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_cmd(rx_cmd), .rx_ext(rx_ext), .rx_garbage(rx_err[0]), .rx_unknown(rx_err[1]),
    .rx_syntax_err(rx_err[2]), .rx_semantic_err(rx_err[3]), .rx_sequence_err(rx_err[4]),
    .tx_valid(tx_valid), .tx_char(tx_char), .tx_last(tx_last), .tx_ready(tx_ready),
    .stream_req(stream_req), .irq(irq));
  cler_sink u_sink (.mclk(mclk), .rst_b(rst_b), .stall(stall), .tx_ready(tx_ready));

  // Random stalls only while a slow remote is wanted
  always @(posedge mclk) stall <= slow && (rnd() % 3 == 0);

  // Output watcher: oldest note against each taken char and read slot
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) begin
      t = tx_q.size() ? tx_q.pop_front() : 9'h1FF;
      `CHK("tx char", t, {tx_last, tx_char})
    end
    if (rd_seen) begin
      t = 9'h000;
      `CHK("reg read", rd_q.pop_front(), reg_rdata)
    end
    rd_seen <= reg_rd;
  end

  // Idle edge after each strobe, so a strobe is never dropped and raised in one step
  task wr(input logic [3:0] a, input logic [31:0] d);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0; reg_wdata <= ~d;
    @(posedge mclk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] x);
    rd_q.push_back(x); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask
  task expect_msg(input string s);
    foreach (s[i]) tx_q.push_back({i == s.len() - 1, s[i]});
  endtask
  // Offer held until taken; released lines then carry junk
  task send(input logic [55:0] sc, input logic [23:0] se, input logic [4:0] sf);
    rx_valid <= 1'b1; rx_cmd <= sc; rx_ext <= se; rx_err <= sf;
    @(posedge mclk);
    while (!rx_ready) @(posedge mclk);
    rx_valid <= 1'b0; rx_cmd <= ~sc; rx_ext <= ~se; rx_err <= 5'(rnd());
  endtask
  task done;
    @(posedge mclk);
    repeat (300) if (tx_q.size() || !rx_ready) @(posedge mclk);
  endtask
  task wrap_up;
    // Notes never answered mean a report or read went missing
    `CHK("notes left", 0, tx_q.size() + rd_q.size())
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    wrap_up;
  end

  initial begin
    seed = 32'hC142; rst_b = 1'b0; {reg_wr, reg_rd, rx_valid, slow} = 4'h0;
    reg_addr = 4'h0; reg_wdata = 32'h0; rx_cmd = 56'h0; rx_ext = 24'h0; rx_err = 5'h00;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(`CLER_OFS_MASK, 32'h0);
    rd(`CLER_OFS_ALARM, 32'h3FF);
    rd(`CLER_OFS_UTC_LO, 32'h30303030);
    rd(4'hF, 32'h0);
    wr(`CLER_OFS_MASK, 32'hFF);
    wr(`CLER_OFS_UTC_HI, 32'h31323A33);
    wr(`CLER_OFS_UTC_LO, 32'h343A3536);
    // Each error kind, with random lower-priority flags beside it
    for (int k = 0; k < 5; k++) begin
      slow <= k[0];
      c = {ch(), ch(), ch(), ch(), ch(), ch(), ch()};
      e = {ch(), ch(), ch()};
      f = (5'h01 << k) | (5'(rnd()) & (5'h1F << (k + 1)));
      expect_msg(k == 0 ? $sformatf("%s %s", `CLER_W_ERR_REPORT, `CLER_X_GARBAGE)
                        : $sformatf("%s %s %s %s", `CLER_W_ERR_REPORT, xw[k], c, e));
      send(c, e, f);
      done;
      rd(`CLER_OFS_STATUS, 32'(1 << k));
      @(posedge mclk);
      `CHK("irq set", 1'b1, irq)
      if (k == 0) begin
        wr(`CLER_OFS_MASK, 32'h0);
        @(posedge mclk);
        `CHK("irq masked", 1'b0, irq)
        wr(`CLER_OFS_MASK, 32'hFF);
      end
      wr(`CLER_OFS_STATUS, 32'(1 << k));
      @(posedge mclk);
      `CHK("irq clear", 1'b0, irq)
    end
    // Offer while busy is dropped and flagged; offered two edges after the accept
    expect_msg($sformatf("%s %s", `CLER_W_ERR_REPORT, `CLER_X_GARBAGE));
    send(c, e, 5'h01);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_err   <= 5'h02;
    @(posedge mclk);
    rx_valid <= 1'b0;
    done;
    rd(`CLER_OFS_STATUS, 32'h81);
    wr(`CLER_OFS_STATUS, 32'h81);
    // Alarm request with every state code
    wr(`CLER_OFS_ALARM, 32'h361);
    expect_msg($sformatf("%s %s 10X1X 12:34:56", `CLER_W_ALARM_STATUS, `CLER_X_REPORT));
    send(`CLER_W_ALARM_STATUS, `CLER_X_REQUEST, 5'h00);
    done;
    rd(`CLER_OFS_STATUS, 32'h20);
    wr(`CLER_OFS_STATUS, 32'h20);
    // Stream request: pulse only, no characters
    send(`CLER_W_STREAM_ERR, `CLER_X_REQUEST, 5'h00);
    @(posedge mclk);
    `CHK("stream pulse", 1'b1, stream_req)
    done;
    rd(`CLER_OFS_STATUS, 32'h40);
    // Clean message that is no request: no report, no new status bit
    send(c, `CLER_X_REPORT, 5'h00);
    done;
    rd(`CLER_OFS_STATUS, 32'h40);
    rd(`CLER_OFS_INFO, 32'h29);
    done;
    wrap_up;
  end
endmodule // cler_reporter_test
`default_nettype wire
